// ---- include/sar_adc_defines.svh ----
// Constants of the converter control block
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
`define RESULT_WIDTH 12
`define RESULT_MSB 11
`define NIBBLE_WIDTH 4
`define UPPER_NIBBLE_LSB 8
`define UPPER_PIN_WIDTH 8
`define FIFO_DEPTH_DEFAULT 16
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 6000
`define STEP_TIME_NS 400
`define STEP_CYCLES ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_TIME_NS 1140
`define SAMPLE_CYCLES ((`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_CNT_WIDTH 8
`endif

// ---- include/sar_adc_pkg.sv ----
// Types of the converter control block
package sar_adc_pkg;
    typedef logic [11:0] result_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_LOAD} conv_state_e;
endpackage

// ---- src/result_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_o = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem[rd_ptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (clk_en_i && push)
        begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else if (clk_en_i)
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/sar_adc_control.sv ----
// Control logic of a 12-bit successive-approximation converter with parallel read
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defines.svh"
module sar_adc_control #(
    parameter int STEP_CYCLES = `STEP_CYCLES,
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic chip_select_n_i,
    input wire logic read_n_i,
    input wire logic high_byte_select_i,
    input wire logic comparator_i,
    output logic [`RESULT_WIDTH-1:0] dac_code_o,
    output logic busy_n_o,
    output logic sample_o,
    output logic [7:0] upper_result_pins_o,
    output logic [3:0] shared_low_result_pins_o,
    output logic [`RESULT_WIDTH-1:0] result_pins_oe_o,
    output sar_adc_pkg::result_t stream_data_o,
    output logic stream_valid_o,
    input wire logic stream_ready_i,
    output logic overrun_o
);
    import sar_adc_pkg::*;

    // ----------------------------------------
    // Pin decode
    // ----------------------------------------
    function automatic logic [`RESULT_WIDTH-1:0] pin_map(input result_t r, input logic hb);
        logic [`RESULT_WIDTH-1:0] v;
        v = r;
        if (hb)
        begin
            v = {r[`RESULT_MSB -: `NIBBLE_WIDTH], {`NIBBLE_WIDTH{1'b0}},
                 r[`RESULT_MSB -: `NIBBLE_WIDTH]};
        end
        return v;
    endfunction

    conv_state_e state_q;
    logic read_n_q;
    logic [`RESULT_WIDTH-1:0] sar_q;
    logic [3:0] bit_idx_q;
    logic [`STEP_CNT_WIDTH-1:0] step_cnt_q;
    result_t latch_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    result_t fifo_out_data;
    logic sel;
    logic read_fall;
    logic start;
    logic step_tick;
    logic [`RESULT_WIDTH-1:0] pin_val;

    assign sel = !chip_select_n_i;
    assign read_fall = read_n_q && !read_n_i;
    assign start = sel && read_fall && !high_byte_select_i
                   && (state_q == ST_IDLE);
    assign step_tick = (step_cnt_q == `STEP_CNT_WIDTH'(STEP_CYCLES - 1));
    assign pin_val = pin_map(latch_q, high_byte_select_i);

    // ----------------------------------------
    // Strobe edge detect
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            read_n_q <= 1'b1;
        else if (clk_en_i)
            read_n_q <= read_n_i;
    end

    // ----------------------------------------
    // Sequencer and step clock
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
            step_cnt_q <= '0;
            bit_idx_q <= '0;
        end
        else if (clk_en_i)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= ST_CONVERT;
                        step_cnt_q <= '0;
                        bit_idx_q <= 4'(`RESULT_MSB);
                    end
                end
                ST_CONVERT:
                begin
                    if (step_tick)
                    begin
                        step_cnt_q <= '0;
                        if (bit_idx_q == 4'h0)
                            state_q <= ST_LOAD;
                        else
                            bit_idx_q <= bit_idx_q - 4'h1;
                    end
                    else
                    begin
                        step_cnt_q <= step_cnt_q + 1'b1;
                    end
                end
                ST_LOAD:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Approximation register
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            sar_q <= '0;
        else if (clk_en_i)
        begin
            if (start)
                sar_q <= {1'b1, {(`RESULT_WIDTH-1){1'b0}}};
            else if (state_q == ST_CONVERT && step_tick)
            begin
                sar_q[bit_idx_q] <= comparator_i;
                if (bit_idx_q != 4'h0)
                    sar_q[bit_idx_q - 4'h1] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Output latch, busy and sample
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            latch_q <= '0;
            busy_n_o <= 1'b1;
            sample_o <= 1'b1;
            dac_code_o <= '0;
        end
        else if (clk_en_i)
        begin
            dac_code_o <= start ? {1'b1, {(`RESULT_WIDTH-1){1'b0}}} : sar_q;
            if (state_q == ST_LOAD)
                latch_q <= sar_q;
            if (start)
            begin
                busy_n_o <= 1'b0;
                sample_o <= 1'b0;
            end
            else if (state_q == ST_LOAD)
            begin
                busy_n_o <= 1'b1;
                sample_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Data pins
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            upper_result_pins_o <= '0;
            shared_low_result_pins_o <= '0;
            result_pins_oe_o <= '0;
        end
        else if (clk_en_i)
        begin
            upper_result_pins_o <= pin_val[`RESULT_MSB -: `UPPER_PIN_WIDTH];
            shared_low_result_pins_o <= pin_val[`NIBBLE_WIDTH-1:0];
            result_pins_oe_o <= {`RESULT_WIDTH{sel && !read_n_i}};
        end
    end

    // ----------------------------------------
    // Result stream
    // ----------------------------------------
    result_fifo #(
        .WIDTH(`RESULT_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(state_q == ST_LOAD),
        .in_ready_o(fifo_in_ready),
        .in_data_i(sar_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(stream_ready_i && !stream_valid_o),
        .out_data_o(fifo_out_data)
    );

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            stream_valid_o <= 1'b0;
            stream_data_o <= '0;
            overrun_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (stream_valid_o)
                stream_valid_o <= 1'b0;
            else if (fifo_out_valid && stream_ready_i)
            begin
                stream_valid_o <= 1'b1;
                stream_data_o <= fifo_out_data;
            end
            overrun_o <= (state_q == ST_LOAD) && !fifo_in_ready;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sar_adc_control_sva.sv ----
// Port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sva #(
    parameter int STEP_CYCLES = 40
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic chip_select_n_i,
    input wire logic read_n_i,
    input wire logic high_byte_select_i,
    input wire logic [11:0] dac_code_o,
    input wire logic busy_n_o,
    input wire logic [7:0] upper_result_pins_o,
    input wire logic [3:0] shared_low_result_pins_o,
    input wire logic [11:0] result_pins_oe_o
);
    logic [15:0] low_cnt_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Length of the current busy run
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i || busy_n_o)
            low_cnt_q <= 16'h0000;
        else
            low_cnt_q <= low_cnt_q + 16'h0001;
    end
    oe_on_a: assert property (!read_n_i && !chip_select_n_i |=> &result_pins_oe_o)
        else $error("drivers off during read");
    oe_off_a: assert property (read_n_i || chip_select_n_i |=> result_pins_oe_o == 12'h000)
        else $error("drivers on outside read");
    start_a: assert property ($fell(read_n_i) && !chip_select_n_i && !high_byte_select_i
        && busy_n_o |=> !busy_n_o) else $error("start not taken");
    start_block_a: assert property ($fell(read_n_i) && (chip_select_n_i || high_byte_select_i)
        && busy_n_o |=> busy_n_o) else $error("start not refused");
    busy_len_a: assert property ($rose(busy_n_o) |-> low_cnt_q == 12 * STEP_CYCLES + 1)
        else $error("busy length wrong");
    busy_cap_a: assert property (!busy_n_o |-> low_cnt_q < 12 * STEP_CYCLES + 1)
        else $error("busy too long");
    msb_trial_a: assert property ($fell(busy_n_o) |-> dac_code_o == 12'h800)
        else $error("first trial not msb");
    high_byte_a: assert property (high_byte_select_i && !read_n_i && !chip_select_n_i |=>
        upper_result_pins_o[3:0] == 4'h0 && shared_low_result_pins_o == upper_result_pins_o[7:4])
        else $error("high byte layout wrong");
endmodule
`default_nettype wire

// ---- tb/sar_adc_front_model.sv ----
// Comparator and result sink at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_front_model (
    input wire logic [11:0] level_i,
    input wire logic [11:0] dac_code_i,
    input wire logic stall_i,
    output logic comparator_o,
    output logic sink_ready_o
);
    assign comparator_o = dac_code_i <= level_i;
    assign sink_ready_o = !stall_i;
endmodule
`default_nettype wire

// ---- tb/sar_adc_control_tb.sv ----
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_tb;
    import sar_adc_pkg::*;
    localparam int STEPS = 2;
    logic clk, rst_n, cs_n, rd_n, hbs, stall, smp, busy_n, cmp, ready, svalid, ovr;
    int ovr_count = 0;
    logic [11:0] level, dac, oe;
    logic [7:0] up;
    logic [3:0] lo;
    result_t sdata;
    result_t words[$];
    int err_count, num_checks;
    sar_adc_control #(.STEP_CYCLES(STEPS)) dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .chip_select_n_i(cs_n),
        .read_n_i(rd_n), .high_byte_select_i(hbs), .comparator_i(cmp), .dac_code_o(dac),
        .busy_n_o(busy_n), .sample_o(smp), .upper_result_pins_o(up), .shared_low_result_pins_o(lo),
        .result_pins_oe_o(oe), .stream_data_o(sdata), .stream_valid_o(svalid),
        .stream_ready_i(ready), .overrun_o(ovr));
    sar_adc_front_model front (.level_i(level), .dac_code_i(dac), .stall_i(stall),
        .comparator_o(cmp), .sink_ready_o(ready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (svalid === 1'b1)
            words.push_back(sdata);
        if (ovr === 1'b1)
            ovr_count <= ovr_count + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_idle;
        int n;
        for (n = 0; n < 300 && busy_n !== 1'b1; n++)
            tick(1);
        if (n == 300)
        begin
            chk("busy timeout", 12'h001, {11'h000, busy_n});
            tally_and_finish();
        end
        tick(115);
    endtask
    task automatic strobe(input logic hb, input logic [11:0] code, input logic [11:0] exp);
        level = code;
        {cs_n, rd_n, hbs} = {2'b00, hb};
        tick(2);
        chk("data pins", exp, {up, lo});
        chk("enables", 12'hfff, oe);
        {cs_n, rd_n, hbs} = 3'b110;
        tick(2);
        chk("enables off", 12'h000, oe);
        wait_idle();
    endtask
    task automatic test_reads;
        strobe(1'b0, 12'ha5c, 12'h000);
        strobe(1'b0, 12'h3c1, 12'ha5c);
        strobe(1'b1, 12'h000, 12'h303);
        strobe(1'b0, 12'hfff, 12'h3c1);
        strobe(1'b1, 12'h000, 12'hf0f);
        $display("reads done");
    endtask
    task automatic test_cs_high;
        {cs_n, rd_n} = 2'b10;
        tick(3);
        chk("enables", 12'h000, oe);
        chk("busy", 12'h001, {11'h000, busy_n});
        chk("sample", 12'h001, {11'h000, smp});
        rd_n = 1'b1;
        tick(2);
        $display("chip select done");
    endtask
    task automatic test_restart;
        level = 12'h6b9;
        {cs_n, rd_n} = 2'b00;
        tick(6);
        chk("sample", 12'h000, {11'h000, smp});
        rd_n = 1'b1;
        tick(1);
        rd_n = 1'b0;
        tick(2);
        {cs_n, rd_n} = 2'b11;
        tick(12 * STEPS + 1 - 8);
        chk("busy", 12'h001, {11'h000, busy_n});
        wait_idle();
        strobe(1'b0, 12'h000, 12'h6b9);
        $display("restart done");
    endtask
    task automatic test_fifo;
        int i;
        int base;
        int ovr0;
        stall = 1'b1;
        base = words.size();
        ovr0 = ovr_count;
        for (i = 0; i < 17; i++)
        begin
            level = 12'h100 + 12'(i);
            {cs_n, rd_n} = 2'b00;
            tick(2);
            {cs_n, rd_n} = 2'b11;
            wait_idle();
        end
        chk("overrun", 12'h001, 12'(ovr_count - ovr0));
        stall = 1'b0;
        tick(60);
        chk("stream count", 12'h010, 12'(words.size() - base));
        for (i = 0; i < 16; i++)
            chk("stream word", 12'h100 + 12'(i), words[base + i]);
        $display("fifo done");
    endtask
    initial
    begin
        {rst_n, cs_n, rd_n, hbs, stall} = 5'b01100;
        level = 12'h000;
        err_count = 0;
        num_checks = 0;
        tick(4);
        rst_n = 1'b1;
        tick(1);
        test_reads();
        test_cs_high();
        test_restart();
        test_fifo();
        tally_and_finish();
    end
endmodule
bind sar_adc_control sar_adc_sva #(.STEP_CYCLES(STEP_CYCLES)) u_sva (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .chip_select_n_i(chip_select_n_i),
    .read_n_i(read_n_i),
    .high_byte_select_i(high_byte_select_i),
    .dac_code_o(dac_code_o),
    .busy_n_o(busy_n_o),
    .upper_result_pins_o(upper_result_pins_o),
    .shared_low_result_pins_o(shared_low_result_pins_o),
    .result_pins_oe_o(result_pins_oe_o)
);
`default_nettype wire
